/* verilog/rsml_regs.sv */
// Purpose: Reference status, status pin driver control and channel 3 mute level registers.
// Assumes: Slew detector indicators are synchronous levels; single clock domain.
// Notes:   Pin drive and channel 3 driver outputs stay in their safe reset state until the startup load completes.
//
// The address-and-strobe port was chosen for this implementation.

module rsml_regs (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst,
   // Register port.
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   // Slew detector indicators.
   input wire logic secondary_rise_valid,
   input wire logic secondary_fall_valid,
   input wire logic primary_rise_valid,
   input wire logic primary_fall_valid,
   // Status pins in and their drive.
   input wire logic status_out_a,
   input wire logic status_out_b,
   output logic status_a_o,
   output logic status_a_oe_n,
   output logic status_b_o,
   output logic status_b_oe_n,
   output logic status_out_a_spike_limit,
   output logic status_out_b_spike_limit,
   // Channel 3 driver state.
   output rsml_pkg::rsml_drv_s chan_three_drv,
   // Startup done and interrupt.
   output logic ready,
   output logic irq
);

   // ************************************************************
   // Declarations
   // ************************************************************
   rsml_pkg::rsml_req_s req;
   logic [7:0] ref_now, ref_last_q, stat_ctl_q, mute_low_q;
   logic [7:0] chan_ctl_q, irq_stat_q, irq_mask_q, rdata_q;
   logic [3:0] nv_addr_q;
   logic [7:0] nv_data, ref_edges;
   rsml_pkg::rsml_drv_s drv_d, drv_q;
   logic st_a_o_q, st_a_oe_n_q, st_b_o_q, st_b_oe_n_q;
   logic irq_q, ready_q;

   typedef enum logic [1:0] {
      RSML_BOOT_ADDR = 2'b00,
      RSML_BOOT_WAIT = 2'b01,
      RSML_BOOT_TAKE = 2'b10,
      RSML_BOOT_DONE = 2'b11
   } rsml_boot_e;
   rsml_boot_e boot_q;

   // Bundle the software strobes; writes other than the interrupt status clear are ignored until startup finishes.
   assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

   // ************************************************************
   // Reference status
   // ************************************************************
   // indicator bit placement
   always_comb
   begin
      ref_now = rsml_pkg::RST_ZERO;
      ref_now[rsml_pkg::BIT_SEC_RISE] = secondary_rise_valid;
      ref_now[rsml_pkg::BIT_SEC_FALL] = secondary_fall_valid;
      ref_now[rsml_pkg::BIT_PRI_RISE] = primary_rise_valid;
      ref_now[rsml_pkg::BIT_PRI_FALL] = primary_fall_valid;
   end

   // Indicators are sampled once so readback and edge events agree.
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         ref_last_q <= rsml_pkg::RST_ZERO;
      end
      else
      begin
         ref_last_q <= ref_now;
      end
   end

   // Any change of an indicator is an event.
   assign ref_edges = (ref_now ^ ref_last_q) & rsml_pkg::REF_STATUS_MASK;

   // ************************************************************
   // Nonvolatile startup load
   // ************************************************************
   rsml_nv_store #(.NV_WORD0(rsml_pkg::RST_STAT_CTL), .NV_WORD1(rsml_pkg::RST_MUTE_LOW)) u_nv (
      .clk_sys(clk_sys), .rst(rst),
      .rd_addr(nv_addr_q), .rd_data(nv_data)
   );

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         boot_q <= RSML_BOOT_ADDR;
         nv_addr_q <= 4'h0;
         ready_q <= 1'b0;
      end
      else
      begin
         unique case (boot_q)
            RSML_BOOT_ADDR: boot_q <= RSML_BOOT_WAIT;
            RSML_BOOT_WAIT: boot_q <= RSML_BOOT_TAKE;
            RSML_BOOT_TAKE:
            begin
               if (nv_addr_q == rsml_pkg::NV_WORDS - 4'h1)
               begin
                  boot_q <= RSML_BOOT_DONE;
                  ready_q <= 1'b1;
               end
               else
               begin
                  nv_addr_q <= nv_addr_q + 4'h1;
                  boot_q <= RSML_BOOT_WAIT;
               end
            end
            RSML_BOOT_DONE: boot_q <= RSML_BOOT_DONE;
         endcase
      end
   end

   // ************************************************************
   // Writable registers
   // ************************************************************
   // pin control storage
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         stat_ctl_q <= rsml_pkg::RST_STAT_CTL;
      end
      else if (boot_q == RSML_BOOT_TAKE && nv_addr_q == 4'h0)
      begin
         stat_ctl_q <= nv_data & rsml_pkg::STAT_CTL_WMASK;
      end
      else if (boot_q == RSML_BOOT_DONE && req.wr && req.addr == rsml_pkg::ADDR_STAT_CTL)
      begin
         stat_ctl_q <= req.wdata & rsml_pkg::STAT_CTL_WMASK;
      end
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         mute_low_q <= rsml_pkg::RST_MUTE_LOW;
      end
      else if (boot_q == RSML_BOOT_TAKE && nv_addr_q == 4'h1)
      begin
         mute_low_q <= nv_data;
      end
      else if (boot_q == RSML_BOOT_DONE && req.wr && req.addr == rsml_pkg::ADDR_MUTE_LOW)
      begin
         mute_low_q <= req.wdata;
      end
   end

   // Channel control: mute enable and single-ended mode select.
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         chan_ctl_q <= rsml_pkg::RST_ZERO;
         irq_mask_q <= rsml_pkg::RST_ZERO;
      end
      else if (boot_q == RSML_BOOT_DONE && req.wr)
      begin
         if (req.addr == rsml_pkg::ADDR_CHAN_CTL)
         begin
            chan_ctl_q <= req.wdata;
         end
         if (req.addr == rsml_pkg::ADDR_IRQ_MASK)
         begin
            irq_mask_q <= req.wdata & rsml_pkg::REF_STATUS_MASK;
         end
      end
   end

   // ************************************************************
   // Interrupts
   // ************************************************************
   // A new edge beats a write-one clear in the same cycle so no event is lost.
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         irq_stat_q <= rsml_pkg::RST_ZERO;
      end
      else
      begin
         irq_stat_q <= (irq_stat_q & ~((req.wr && req.addr == rsml_pkg::ADDR_IRQ_STATUS)
            ? req.wdata : rsml_pkg::RST_ZERO)) | ref_edges;
      end
   end

   // Level interrupt, registered so it comes straight from a flop.
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         irq_q <= 1'b0;
      end
      else
      begin
         irq_q <= |(irq_stat_q & irq_mask_q);
      end
   end

   // ************************************************************
   // Read port
   // ************************************************************
   // Unmapped addresses read as zero; reads have no side effects.
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         rdata_q <= rsml_pkg::RST_ZERO;
      end
      else if (req.rd)
      begin
         unique case (req.addr)
            rsml_pkg::ADDR_REF_STATUS: rdata_q <= ref_last_q;
            rsml_pkg::ADDR_STAT_CTL: rdata_q <= stat_ctl_q;
            rsml_pkg::ADDR_MUTE_LOW: rdata_q <= mute_low_q;
            rsml_pkg::ADDR_IRQ_STATUS: rdata_q <= irq_stat_q;
            rsml_pkg::ADDR_IRQ_MASK: rdata_q <= irq_mask_q;
            rsml_pkg::ADDR_CHAN_CTL: rdata_q <= chan_ctl_q;
            default: rdata_q <= rsml_pkg::RST_ZERO;
         endcase
      end
      else
      begin
         rdata_q <= rsml_pkg::RST_ZERO;
      end
   end

   // ************************************************************
   // Status pin drivers
   // ************************************************************
   // open drain only drives low; push-pull drives both levels.
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         st_a_o_q <= 1'b0;
         st_a_oe_n_q <= 1'b1;
         st_b_o_q <= 1'b0;
         st_b_oe_n_q <= 1'b1;
      end
      else if (boot_q == RSML_BOOT_DONE)
      begin
         st_a_o_q <= stat_ctl_q[rsml_pkg::BIT_A_OPEN] ? 1'b0 : status_out_a;
         st_a_oe_n_q <= stat_ctl_q[rsml_pkg::BIT_A_OPEN] ? status_out_a : 1'b0;
         st_b_o_q <= stat_ctl_q[rsml_pkg::BIT_B_OPEN] ? 1'b0 : status_out_b;
         st_b_oe_n_q <= stat_ctl_q[rsml_pkg::BIT_B_OPEN] ? status_out_b : 1'b0;
      end
   end

   // ************************************************************
   // Channel 3 mute decode
   // ************************************************************
   // level decode under mute gate
   always_comb
   begin
      drv_d = '0;
      if (chan_ctl_q[rsml_pkg::BIT_CH3_MUTE])
      begin
         unique case (rsml_pkg::rsml_mute_e'(mute_low_q[rsml_pkg::MUTE3_LSB +: 2]))
            rsml_pkg::RSML_MUTE_BYPASS: drv_d = '0;
            rsml_pkg::RSML_MUTE_LOW:
            begin
               drv_d.diff_pdn = ~chan_ctl_q[rsml_pkg::BIT_CH3_CMOS];
               drv_d.n_force_low = chan_ctl_q[rsml_pkg::BIT_CH3_CMOS];
            end
            rsml_pkg::RSML_MUTE_HIGH:
            begin
               drv_d.p_force_high = ~chan_ctl_q[rsml_pkg::BIT_CH3_CMOS];
               drv_d.p_force_low = chan_ctl_q[rsml_pkg::BIT_CH3_CMOS];
            end
            rsml_pkg::RSML_MUTE_RAIL:
            begin
               drv_d.p_force_low = chan_ctl_q[rsml_pkg::BIT_CH3_CMOS];
               drv_d.p_force_high = ~chan_ctl_q[rsml_pkg::BIT_CH3_CMOS];
               drv_d.n_force_low = 1'b1;
            end
         endcase
      end
   end

   // driver state held off until load done
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         drv_q <= '0;
      end
      else
      begin
         drv_q <= (boot_q == RSML_BOOT_DONE) ? drv_d : '0;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign rdata = rdata_q;
   assign status_a_o = st_a_o_q;
   assign status_a_oe_n = st_a_oe_n_q;
   assign status_b_o = st_b_o_q;
   assign status_b_oe_n = st_b_oe_n_q;
   assign status_out_a_spike_limit = stat_ctl_q[rsml_pkg::BIT_A_LIMIT];
   assign status_out_b_spike_limit = stat_ctl_q[rsml_pkg::BIT_B_LIMIT];
   assign chan_three_drv = drv_q;
   assign ready = ready_q;
   assign irq = irq_q;

   // ************************************************************
   // Assertions
   // ************************************************************
   a_ref_readback: assert property (@(posedge clk_sys) disable iff (rst)
      rd && addr == rsml_pkg::ADDR_REF_STATUS |=> rdata[7:6] == $past(ref_last_q[7:6]))
      else $error("Secondary indicator readback wrong.");
   a_pri_readback: assert property (@(posedge clk_sys) disable iff (rst)
      rd && addr == rsml_pkg::ADDR_REF_STATUS |=> rdata[5:4] == $past(ref_now[5:4], 2))
      else $error("Primary indicator readback wrong.");
   a_b_open_drain: assert property (@(posedge clk_sys) disable iff (rst)
      ready && stat_ctl_q[1] |=> status_b_o == 1'b0 && status_b_oe_n == $past(status_out_b))
      else $error("Status B open drain drive wrong.");
   a_a_push_pull: assert property (@(posedge clk_sys) disable iff (rst)
      ready && !stat_ctl_q[0] |=> status_a_oe_n == 1'b0 && status_a_o == $past(status_out_a))
      else $error("Status A drive wrong.");
   a_limit_write: assert property (@(posedge clk_sys) disable iff (rst)
      ready && wr && addr == rsml_pkg::ADDR_STAT_CTL
      |=> status_out_b_spike_limit == $past(wdata[5]) && status_out_a_spike_limit == $past(wdata[4]))
      else $error("Spike limit write not applied.");
   a_mute_write: assert property (@(posedge clk_sys) disable iff (rst)
      ready && wr && addr == rsml_pkg::ADDR_MUTE_LOW |=> mute_low_q[7:6] == $past(wdata[7:6]))
      else $error("Mute level write not applied.");
   a_level_one: assert property (@(posedge clk_sys) disable iff (rst)
      ready && chan_ctl_q[0] && !chan_ctl_q[1] && mute_low_q[7:6] == 2'b01 |=> drv_q.diff_pdn)
      else $error("Level one differential power down missing.");
   a_unmuted_idle: assert property (@(posedge clk_sys) disable iff (rst)
      !chan_ctl_q[0] |=> drv_q == '0)
      else $error("Driver forced without mute.");
   a_boot_quiet: assert property (@(posedge clk_sys) disable iff (rst)
      !ready |-> status_a_oe_n && status_b_oe_n && drv_q == '0)
      else $error("Outputs active before startup load.");

endmodule : rsml_regs

/* verilog/rsml_pkg.sv */
// Purpose: Shared constants and carriers for the reference status and mute level registers.
// Assumes: Byte-wide registers on a plain strobe port, one clock, asynchronous reset.
// Notes:   Offsets are the printed register indices used as plain addresses.
package rsml_pkg;

   // ************************************************************
   // Register map
   // ************************************************************
   localparam logic [7:0] ADDR_REF_STATUS = 8'h12;
   localparam logic [7:0] ADDR_STAT_CTL = 8'h13;
   localparam logic [7:0] ADDR_MUTE_LOW = 8'h14;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h40;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h41;
   localparam logic [7:0] ADDR_CHAN_CTL = 8'h42;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int BIT_SEC_RISE = 7;
   localparam int BIT_SEC_FALL = 6;
   localparam int BIT_PRI_RISE = 5;
   localparam int BIT_PRI_FALL = 4;
   localparam int BIT_B_LIMIT = 5;
   localparam int BIT_A_LIMIT = 4;
   localparam int BIT_B_OPEN = 1;
   localparam int BIT_A_OPEN = 0;
   localparam int MUTE3_LSB = 6;
   localparam int BIT_CH3_MUTE = 0;
   localparam int BIT_CH3_CMOS = 1;

   // ************************************************************
   // Reset values and masks
   // ************************************************************
   localparam logic [7:0] RST_STAT_CTL = 8'h00;
   localparam logic [7:0] RST_MUTE_LOW = 8'h40;
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] STAT_CTL_WMASK = 8'h3f;
   localparam logic [7:0] REF_STATUS_MASK = 8'hf0;
   localparam logic [3:0] NV_WORDS = 4'h2;

   // ************************************************************
   // Mute levels
   // ************************************************************
   typedef enum logic [1:0] {
      RSML_MUTE_BYPASS = 2'b00,
      RSML_MUTE_LOW = 2'b01,
      RSML_MUTE_HIGH = 2'b10,
      RSML_MUTE_RAIL = 2'b11
   } rsml_mute_e;

   // Driver state applied to one output channel.
   typedef struct packed {
      logic diff_pdn;
      logic p_force_low;
      logic p_force_high;
      logic n_force_low;
   } rsml_drv_s;

   // Software port request.
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } rsml_req_s;

endpackage : rsml_pkg

/* verilog/rsml_nv_store.sv */
// Purpose: Small nonvolatile image model holding the startup register values.
// Assumes: Contents are fixed constants; read data come from a register.
// Notes:   Word 0 feeds the status pin control, word 1 the mute level register.
module rsml_nv_store #(
   parameter logic [7:0] NV_WORD0 = 8'h00,
   parameter logic [7:0] NV_WORD1 = 8'h40
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst,
   // Read port.
   input wire logic [3:0] rd_addr,
   output logic [7:0] rd_data
);

   // Read data are registered so the loader sees one cycle of latency.
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         rd_data <= rsml_pkg::RST_ZERO;
      end
      else
      begin
         rd_data <= (rd_addr == 4'h0) ? NV_WORD0 : NV_WORD1;
      end
   end

endmodule : rsml_nv_store

/* verification/rsml_regs_tb_top.sv */
// Purpose: Self-checking bench for the reference status, pin control and mute level registers.
// Assumes: Startup load ends within 20 clocks; outputs settle within 3 clocks of a write.
// Notes:   Inputs change by non-blocking assignment at the rising edge.
module rsml_regs_tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   // ************************************************************
   // Signals and design
   // ************************************************************
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] rdata;
   logic [3:0] det = 4'h0;
   logic sa = 1'b0;
   logic sb = 1'b0;
   logic a_o, a_oe_n, b_o, b_oe_n, lim_a, lim_b, ready, irq;
   rsml_pkg::rsml_drv_s drv;
   int error_cnt = 0;
   int total_checks = 0;

   // Half period of 10 ns gives the 50 MHz system clock.
   always #10 clk_sys = ~clk_sys;

   rsml_regs DUT (
      .clk_sys(clk_sys), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .secondary_rise_valid(det[3]), .secondary_fall_valid(det[2]),
      .primary_rise_valid(det[1]), .primary_fall_valid(det[0]),
      .status_out_a(sa), .status_out_b(sb), .status_a_o(a_o), .status_a_oe_n(a_oe_n),
      .status_b_o(b_o), .status_b_oe_n(b_oe_n), .status_out_a_spike_limit(lim_a),
      .status_out_b_spike_limit(lim_b), .chan_three_drv(drv), .ready(ready), .irq(irq)
   );

   // ************************************************************
   // Shared tasks
   // ************************************************************
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // One write strobe cycle, then release at the next edge.
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk_sys);
      wr <= 1'b0;
   endtask : wr_reg

   // Read data stand only in the cycle after the strobe, so sample there.
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string name);
      @(posedge clk_sys);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk_sys);
      rd <= 1'b0;
      #1;
      check(name, rdata, exp);
   endtask : rd_chk

   task automatic settle();
      repeat (3) @(posedge clk_sys);
      #1;
   endtask : settle

   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_startup();
      int n;
      n = 0;
      #1;
      check("ready_in_load", {7'h00, ready}, 8'h00);
      // An early write must be lost under the startup load.
      wr_reg(rsml_pkg::ADDR_STAT_CTL, 8'h33);
      while (ready !== 1'b1 && n < 20)
      begin
         @(posedge clk_sys);
         n++;
      end
      #1;
      check("ready", {7'h00, ready}, 8'h01);
      rd_chk(rsml_pkg::ADDR_REF_STATUS, 8'h00, "ref_rst");
      rd_chk(rsml_pkg::ADDR_STAT_CTL, 8'h00, "ctl_rst");
      rd_chk(rsml_pkg::ADDR_MUTE_LOW, 8'h40, "mute_rst");
      check("lims_rst", {6'h00, lim_b, lim_a}, 8'h00);
      $display("test startup done");
   endtask : t_startup

   task automatic t_ref_status();
      // Each detector alone, then all, so a swapped position shows.
      for (int i = 0; i < 5; i++)
      begin
         @(posedge clk_sys);
         det <= (i == 4) ? 4'hf : 4'h1 << i;
         settle();
         rd_chk(rsml_pkg::ADDR_REF_STATUS, (i == 4) ? 8'hf0 : 8'h10 << i, "ref_bits");
      end
      wr_reg(rsml_pkg::ADDR_REF_STATUS, 8'h00);
      rd_chk(rsml_pkg::ADDR_REF_STATUS, 8'hf0, "ref_ro");
      rd_chk(8'h20, 8'h00, "unmapped");
      @(posedge clk_sys);
      det <= 4'h0;
      settle();
      $display("test ref_status done");
   endtask : t_ref_status

   task automatic t_pins();
      // Push-pull drives the level with the enable low.
      @(posedge clk_sys);
      sa <= 1'b1;
      sb <= 1'b0;
      settle();
      check("pp_pins", {a_o, a_oe_n, b_o, b_oe_n}, 8'h08);
      wr_reg(rsml_pkg::ADDR_STAT_CTL, 8'hff);
      rd_chk(rsml_pkg::ADDR_STAT_CTL, 8'h3f, "ctl_rw");
      settle();
      check("lims_on", {6'h00, lim_b, lim_a}, 8'h03);
      // Open drain holds data low and releases the pin for a high level.
      check("od_pins", {a_o, a_oe_n, b_o, b_oe_n}, 8'h04);
      @(posedge clk_sys);
      sa <= 1'b0;
      sb <= 1'b1;
      settle();
      check("od_swap", {a_o, a_oe_n, b_o, b_oe_n}, 8'h01);
      wr_reg(rsml_pkg::ADDR_STAT_CTL, 8'h11);
      settle();
      check("mixed", {lim_b, lim_a, a_o, a_oe_n, b_o, b_oe_n}, 8'h12);
      $display("test pins done");
   endtask : t_pins

   task automatic t_mute();
      // Level 1 with mute off leaves the driver untouched.
      wr_reg(rsml_pkg::ADDR_CHAN_CTL, 8'h00);
      settle();
      check("no_mute", {4'h0, drv}, 8'h00);
      wr_reg(rsml_pkg::ADDR_CHAN_CTL, 8'h01);
      settle();
      check("lvl1_diff", {4'h0, drv}, 8'h08);
      wr_reg(rsml_pkg::ADDR_CHAN_CTL, 8'h03);
      settle();
      check("lvl1_se", {4'h0, drv}, 8'h01);
      wr_reg(rsml_pkg::ADDR_MUTE_LOW, 8'h00);
      settle();
      check("lvl0_se", {4'h0, drv}, 8'h00);
      wr_reg(rsml_pkg::ADDR_CHAN_CTL, 8'h01);
      settle();
      check("lvl0_diff", {4'h0, drv}, 8'h00);
      wr_reg(rsml_pkg::ADDR_MUTE_LOW, 8'hc0);
      rd_chk(rsml_pkg::ADDR_MUTE_LOW, 8'hc0, "mute_rw");
      // Levels 2 and 3 under mute, in both output modes.
      settle();
      check("lvl3_diff", {4'h0, drv}, 8'h03);
      wr_reg(rsml_pkg::ADDR_CHAN_CTL, 8'h03);
      settle();
      check("lvl3_se", {4'h0, drv}, 8'h05);
      wr_reg(rsml_pkg::ADDR_MUTE_LOW, 8'h80);
      settle();
      check("lvl2_se", {4'h0, drv}, 8'h04);
      wr_reg(rsml_pkg::ADDR_CHAN_CTL, 8'h01);
      settle();
      check("lvl2_diff", {4'h0, drv}, 8'h02);
      $display("test mute done");
   endtask : t_mute

   task automatic t_irq();
      wr_reg(rsml_pkg::ADDR_IRQ_STATUS, 8'hf0);
      wr_reg(rsml_pkg::ADDR_IRQ_MASK, 8'hf0);
      rd_chk(rsml_pkg::ADDR_IRQ_STATUS, 8'h00, "irq_clr0");
      @(posedge clk_sys);
      det <= 4'h2;
      settle();
      rd_chk(rsml_pkg::ADDR_IRQ_STATUS, 8'h20, "irq_set");
      check("irq_on", {7'h00, irq}, 8'h01);
      wr_reg(rsml_pkg::ADDR_IRQ_MASK, 8'h00);
      settle();
      check("irq_masked", {7'h00, irq}, 8'h00);
      wr_reg(rsml_pkg::ADDR_IRQ_MASK, 8'h20);
      settle();
      check("irq_unmask", {7'h00, irq}, 8'h01);
      wr_reg(rsml_pkg::ADDR_IRQ_STATUS, 8'h20);
      settle();
      check("irq_off", {7'h00, irq}, 8'h00);
      rd_chk(rsml_pkg::ADDR_IRQ_STATUS, 8'h00, "irq_clr");
      $display("test irq done");
   endtask : t_irq

   // ************************************************************
   // Verdict and main sequence
   // ************************************************************
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
      begin
         $display("ALL TESTS PASSED");
      end
      else
      begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : tally_and_finish

   // The whole run is under 400 clocks, so 5000 means a hang.
   initial
   begin
      #100000;
      error_cnt++;
      tally_and_finish();
   end

   initial
   begin
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      t_startup();
      t_ref_status();
      t_pins();
      t_mute();
      t_irq();
      tally_and_finish();
   end
endmodule : rsml_regs_tb_top
